/* File: core/lifc_pkg.sv */
// Purpose: Shared constants and types of the line interface control block
// Assumes: Reference clock of 25 MHz; the mode pin arrives as two
//          comparator levels (below low threshold, above high threshold)
// Notes:   Cycle counts are derived from times in ns and the clock rate
package lifc_pkg;

  // Reference clock rate in kHz
  localparam int REF_CLK_KHZ = 25000;

  // Operating mode, decoded from the three-level mode pin
  typedef enum logic [1:0] {
    MODE_PIN   = 2'h0,
    MODE_LATCH = 2'h1,
    MODE_HOST  = 2'h2
  } lifc_mode_e;

  // Pulse driver states
  typedef enum logic [1:0] {
    PS_IDLE  = 2'h1,
    PS_DRIVE = 2'h2
  } lifc_pulse_e;

  // Line-length codes
  localparam logic [2:0] LEN_E1_120 = 3'h0;
  localparam logic [2:0] LEN_E1_75 = 3'h1;
  localparam logic [2:0] LEN_NET_A = 3'h2;
  localparam logic [2:0] LEN_NET_B = 3'h3;
  localparam logic [2:0] LEN_DSX_FIRST = 3'h3;

  // Pulse widths; nominal figures, rounded down to whole cycles
  localparam int PW_E1_NS = 244;
  localparam int PW_NET_A_NS = 324;
  localparam int PW_DSX_NS = 350;
  localparam int PW_E1_CYC = (PW_E1_NS * REF_CLK_KHZ) / 1000000;
  localparam int PW_NET_A_CYC = (PW_NET_A_NS * REF_CLK_KHZ) / 1000000;
  localparam int PW_DSX_CYC = (PW_DSX_NS * REF_CLK_KHZ) / 1000000;

  // Transmit clock counts as static after this long without a bit
  localparam int STATIC_NS = 1000;
  localparam int STATIC_CYC = (STATIC_NS * REF_CLK_KHZ + 999999) / 1000000;

  // Settling intervals in bit periods
  localparam int SETTLE_BITS = 22;
  localparam int SETTLE_REMOTE_LOOPBACK_BITS = 44;

  // Receive slicing thresholds in percent of peak
  localparam logic [6:0] SLICE_E1_PCT = 7'h32;
  localparam logic [6:0] SLICE_T1_PCT = 7'h41;

  // Zero substitution: delay depth and patterns, oldest bit at the top
  localparam int DELAY_LEN = 8;
  localparam logic [7:0] B8ZS_MARK = 8'h1b;
  localparam logic [7:0] B8ZS_VIOL = 8'h12;
  localparam int HDB3_V_POS = 4;

  // Control pin indices (pins 23 to 28) in pin modes and host mode
  localparam int CP_LINE_LENGTH_BIT0 = 0;
  localparam int CP_REMOTE_LOOPBACK = 3;
  localparam int CP_LOCAL_LOOPBACK = 4;
  localparam int CP_SEND_ALL_ONES = 5;
  localparam int CP_INT = 0;
  localparam int CP_SDI = 1;
  localparam int CP_SDO = 2;
  localparam int CP_CS = 3;
  localparam int CP_SCLK = 4;
  localparam int CP_OUTPUT_EDGE_SELECT = 5;

  // Mode comparator bits
  localparam int MP_LOW = 0;
  localparam int MP_HIGH = 1;

  // Counter widths
  localparam int PW_W = 4;
  localparam int CNT_W = 6;

endpackage : lifc_pkg

/* File: core/lifc_sync.sv */
// Purpose: Two-stage synchroniser for levels entering a clock domain
// Assumes: Each bit is a level held for several destination cycles
// Notes:   Bits are synchronised independently; a multi-bit value may
//          show a mix of old and new for one cycle while it changes
`timescale 1ns/1ps
module lifc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // The first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule : lifc_sync

/* File: core/lifc_top.sv */
// Purpose: Mode selection, pin muxing and transmit control of a T1/E1
//          line interface
// Assumes: Serial port, receiver and monitor cores sit outside
// Notes:   Transmit clock must be slower than a quarter of ref_clk
// Function
// - Mode pin level picks one of three modes
// - Pin modes use dedicated pins, no registers
// - Latched mode captures shared controls under chip select
// - Host mode exposes four-wire serial port pins
// - Internal line coding only in latched mode
// - AIS in latched mode, monitor otherwise
// - Twelve multi-function pins reassigned per mode
// - Transmit data sampled on transmit clock fall
// - Codes 011 to 111 pick cable ranges
// - Pulse width follows line-length code automatically
// - Codes 000 and 001 pick E1 outputs
// - Codes 010 and 011 pick network options
// - Static transmit clock forces line outputs low
// - Control change starts 22-bit settling interval
// - Remote loopback lengthens the settling interval
// - E1 pulse width timed by internal clock
// - All-ones sends ones unless remote loopback
// - Slicing threshold 50% E1, 65% T1
`timescale 1ns/1ps
module lifc_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic txClk,
  input wire logic [1:0] modeLevelPins,
  input wire logic [1:0] txDataPins,
  input wire logic [1:0] monitorPins,
  input wire logic [5:0] ctlPinsIn,
  output logic [5:0] ctlPinsOut,
  output logic [5:0] ctlPinsOe,
  input wire logic rxPositiveData,
  input wire logic rxNegativeData,
  input wire logic rxSingleData,
  input wire logic bipolarViolationFlag,
  input wire logic aisFlag,
  input wire logic driverMonitorFlag,
  output logic [1:0] rxPinsOut,
  output logic statusPinOut,
  input wire logic [2:0] hostLineLengthCode,
  input wire logic hostRemoteLoopback,
  input wire logic hostLocalLoopback,
  input wire logic hostSendAllOnes,
  input wire logic hostSerialOut,
  input wire logic hostInterrupt,
  output logic serialChipSelectN,
  output logic serialClk,
  output logic serialIn,
  output logic outputEdgeSelect,
  output logic monitorTipIn,
  output logic monitorRingIn,
  output lifc_pkg::lifc_mode_e modeSel,
  output logic [2:0] lineLengthCode,
  output logic remoteLoopback,
  output logic localLoopback,
  output logic sendAllOnes,
  output logic rxDecoderSelect,
  output logic internalCoding,
  output logic aisEnable,
  output logic driverMonitorEnable,
  output logic e1Output,
  output logic e1NoResistor,
  output logic networkOptA,
  output logic networkOptB,
  output logic dsxSelect,
  output logic [2:0] dsxRange,
  output logic [6:0] sliceThresholdPct,
  output logic lineOutA,
  output logic lineOutB,
  output logic txClkStatic,
  output logic txSettling
);
  import lifc_pkg::*;

  // Pin synchroniser: mode, monitor, control pins and the coder pin
  logic [10:0] pinRaw;
  logic [10:0] pinSync;
  logic [1:0] modeS;
  logic [1:0] monS;
  logic [5:0] ctlS;
  logic tcodeS;
  assign pinRaw = {txDataPins[1], ctlPinsIn, monitorPins, modeLevelPins};
  assign modeS = pinSync[1:0];
  assign monS = pinSync[3:2];
  assign ctlS = pinSync[9:4];
  assign tcodeS = pinSync[10];

  lifc_sync #(.WIDTH(11)) u_pin_sync (
    .clk(ref_clk),
    .rst_n(arst_n),
    .d(pinRaw),
    .q(pinSync)
  );

  // Mode decode: taken only when two samples agree
  lifc_mode_e modeReg, modeNext, modeSampleReg, modeDecoded;
  always_comb begin
    if (modeS[MP_HIGH]) begin
      modeDecoded = MODE_HOST;
    end else if (modeS[MP_LOW]) begin
      modeDecoded = MODE_PIN;
    end else begin
      modeDecoded = MODE_LATCH;
    end
    modeNext = (modeDecoded == modeSampleReg) ? modeDecoded : modeReg;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeReg <= MODE_PIN;
      modeSampleReg <= MODE_PIN;
    end else begin
      modeReg <= modeNext;
      modeSampleReg <= modeDecoded;
    end
  end

  // Control latch {tx_coder_select, rx_decoder_select, send_all_ones, local_loopback, remote_loopback, len}
  logic [7:0] latchReg, latchNext;
  always_comb begin
    latchNext = latchReg;
    if (!monS[1]) begin
      latchNext = {tcodeS, monS[0], ctlS};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latchReg <= 8'h00;
    end else begin
      latchReg <= latchNext;
    end
  end

  // Effective configuration, chosen by mode
  logic [2:0] lenReg, lenNext;
  logic rloopReg, rloopNext, lloopReg, lloopNext, taosReg, taosNext;
  logic amiReg, amiNext, rxDecReg, rxDecNext;
  always_comb begin
    lenNext = ctlS[2:0];
    rloopNext = ctlS[CP_REMOTE_LOOPBACK];
    lloopNext = ctlS[CP_LOCAL_LOOPBACK];
    taosNext = ctlS[CP_SEND_ALL_ONES];
    amiNext = 1'b0;
    rxDecNext = 1'b0;
    case (modeReg)
      MODE_LATCH: begin
        {amiNext, rxDecNext, taosNext, lloopNext, rloopNext, lenNext} =
          latchReg;
      end
      MODE_HOST: begin
        lenNext = hostLineLengthCode;
        rloopNext = hostRemoteLoopback;
        lloopNext = hostLocalLoopback;
        taosNext = hostSendAllOnes;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lenReg <= LEN_E1_120;
      rloopReg <= 1'b0;
      lloopReg <= 1'b0;
      taosReg <= 1'b0;
      amiReg <= 1'b0;
      rxDecReg <= 1'b0;
    end else begin
      lenReg <= lenNext;
      rloopReg <= rloopNext;
      lloopReg <= lloopNext;
      taosReg <= taosNext;
      amiReg <= amiNext;
      rxDecReg <= rxDecNext;
    end
  end

  // Decoded configuration outputs
  logic isLatched, isHost, isE1;
  assign isLatched = (modeReg == MODE_LATCH);
  assign isHost = (modeReg == MODE_HOST);
  assign isE1 = (lenReg == LEN_E1_120) || (lenReg == LEN_E1_75);
  assign modeSel = modeReg;
  assign lineLengthCode = lenReg;
  assign remoteLoopback = rloopReg;
  assign localLoopback = lloopReg;
  assign sendAllOnes = taosReg;
  assign rxDecoderSelect = rxDecReg;
  assign internalCoding = isLatched;
  assign aisEnable = isLatched;
  assign driverMonitorEnable = !isLatched;
  assign e1Output = isE1;
  assign e1NoResistor = (lenReg == LEN_E1_75);
  assign networkOptA = (lenReg == LEN_NET_A);
  assign networkOptB = (lenReg == LEN_NET_B);
  assign dsxSelect = (lenReg >= LEN_DSX_FIRST);
  assign dsxRange = dsxSelect ? 3'(lenReg - LEN_DSX_FIRST) : 3'h0;
  assign sliceThresholdPct = isE1 ? SLICE_E1_PCT : SLICE_T1_PCT;

  // Multi-function pin routing, registered so outputs are glitch free
  logic [1:0] rxPinsReg, rxPinsNext;
  logic statusReg, statusNext;
  logic [5:0] ctlOutReg, ctlOutNext, ctlOeReg, ctlOeNext;
  logic [5:0] serReg, serNext;
  always_comb begin
    rxPinsNext = {rxPositiveData, rxNegativeData};
    statusNext = driverMonitorFlag;
    ctlOutNext = 6'h00;
    ctlOeNext = 6'h00;
    serNext = {monS[0], monS[1], 4'h8}; // Serial pins idle deselected
    if (isLatched) begin
      rxPinsNext = {rxSingleData, bipolarViolationFlag};
      statusNext = aisFlag;
      serNext = {2'h0, 4'h8};
    end else if (isHost) begin
      ctlOutNext[CP_INT] = hostInterrupt;
      ctlOeNext[CP_INT] = 1'b1;
      ctlOutNext[CP_SDO] = hostSerialOut;
      ctlOeNext[CP_SDO] = !ctlS[CP_CS]; // Released while deselected
      serNext[3:0] = {ctlS[CP_CS], ctlS[CP_SCLK], ctlS[CP_SDI],
                      ctlS[CP_OUTPUT_EDGE_SELECT]};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxPinsReg <= 2'h0;
      statusReg <= 1'b0;
      ctlOutReg <= 6'h00;
      ctlOeReg <= 6'h00;
      serReg <= 6'h08;
    end else begin
      rxPinsReg <= rxPinsNext;
      statusReg <= statusNext;
      ctlOutReg <= ctlOutNext;
      ctlOeReg <= ctlOeNext;
      serReg <= serNext;
    end
  end

  assign rxPinsOut = rxPinsReg;
  assign statusPinOut = statusReg;
  assign ctlPinsOut = ctlOutReg;
  assign ctlPinsOe = ctlOeReg;
  assign {monitorTipIn, monitorRingIn, serialChipSelectN, serialClk,
          serialIn, outputEdgeSelect} = serReg;

  // Link domain runs on the falling transmit clock edge
  logic txClkN;
  assign txClkN = ~txClk;

  // Configuration levels into the link domain
  logic [3:0] cfgLink;
  logic latchedL, e1L, amiL, taosL;
  assign {latchedL, e1L, amiL, taosL} = cfgLink;
  lifc_sync #(.WIDTH(4)) u_cfg_sync (
    .clk(txClkN),
    .rst_n(arst_n),
    .d({isLatched, isE1, amiReg, taosReg && !rloopReg}),
    .q(cfgLink)
  );

  // Encoder: delay line lets zero runs be replaced before they leave
  logic [DELAY_LEN-1:0] dlMarkReg, dlMarkNext, dlViolReg, dlViolNext;
  logic lastPolReg, lastPolNext, parityReg, parityNext;
  logic symPosReg, symPosNext, symNegReg, symNegNext;
  logic bitTglReg;
  logic outMark, outViol, pol;
  always_comb begin
    dlMarkNext = {dlMarkReg[DELAY_LEN-2:0], txDataPins[0]};
    dlViolNext = {dlViolReg[DELAY_LEN-2:0], 1'b0};
    if (!amiL && !taosL) begin
      if (e1L && dlMarkNext[7:4] == 4'h0) begin
        dlMarkNext[HDB3_V_POS] = 1'b1;
        dlViolNext[HDB3_V_POS] = 1'b1;
        dlMarkNext[7] = !parityReg; // Balancing pulse when even
      end else if (!e1L && dlMarkNext == 8'h00) begin
        dlMarkNext = B8ZS_MARK;
        dlViolNext = B8ZS_VIOL;
      end
    end
    outMark = dlMarkNext[7];
    outViol = dlViolNext[7];
    if (taosL) begin
      outMark = 1'b1;
      outViol = 1'b0;
    end
    pol = outViol ? lastPolReg : !lastPolReg;
    lastPolNext = lastPolReg;
    parityNext = parityReg;
    symPosNext = txDataPins[0];
    symNegNext = txDataPins[1];
    if (latchedL || taosL) begin
      symPosNext = outMark && pol;
      symNegNext = outMark && !pol;
      if (outMark) begin
        lastPolNext = pol;
        parityNext = outViol ? 1'b0 : !parityReg;
      end
    end
  end

  always_ff @(posedge txClkN or negedge arst_n) begin
    if (!arst_n) begin
      dlMarkReg <= '0;
      dlViolReg <= '0;
      lastPolReg <= 1'b0;
      parityReg <= 1'b0;
      symPosReg <= 1'b0;
      symNegReg <= 1'b0;
      bitTglReg <= 1'b0;
    end else begin
      dlMarkReg <= dlMarkNext;
      dlViolReg <= dlViolNext;
      lastPolReg <= lastPolNext;
      parityReg <= parityNext;
      symPosReg <= symPosNext;
      symNegReg <= symNegNext;
      bitTglReg <= !bitTglReg;
    end
  end

  // Bit event back to the reference domain; symbol is stable by then
  logic tglS;
  logic tglSeenReg;
  logic newBit;
  lifc_sync #(.WIDTH(1)) u_tgl_sync (
    .clk(ref_clk),
    .rst_n(arst_n),
    .d(bitTglReg),
    .q(tglS)
  );
  assign newBit = tglS ^ tglSeenReg;

  // Static clock watch and settling counter
  logic [CNT_W-1:0] staticCntReg, staticCntNext, settleCntReg, settleCntNext;
  logic [5:0] watchReg;
  logic watchChange;
  assign watchChange = (watchReg != {taosReg, lenReg, lloopReg, rloopReg});
  always_comb begin
    staticCntNext = staticCntReg;
    if (newBit) begin
      staticCntNext = '0;
    end else if (staticCntReg != CNT_W'(STATIC_CYC)) begin
      staticCntNext = staticCntReg + 1'b1;
    end
    settleCntNext = settleCntReg;
    if (watchChange) begin
      settleCntNext = rloopReg ? CNT_W'(SETTLE_REMOTE_LOOPBACK_BITS)
                               : CNT_W'(SETTLE_BITS);
    end else if (newBit && settleCntReg != '0) begin
      settleCntNext = settleCntReg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tglSeenReg <= 1'b0;
      staticCntReg <= CNT_W'(STATIC_CYC);
      settleCntReg <= '0;
      watchReg <= 6'h00;
    end else begin
      tglSeenReg <= tglS;
      staticCntReg <= staticCntNext;
      settleCntReg <= settleCntNext;
      watchReg <= {taosReg, lenReg, lloopReg, rloopReg};
    end
  end

  assign txClkStatic = (staticCntReg == CNT_W'(STATIC_CYC));
  assign txSettling = (settleCntReg != '0);

  // Pulse driver: width counted on ref_clk, not on the transmit clock
  lifc_pulse_e stateReg, stateNext;
  logic [PW_W-1:0] widthCntReg, widthCntNext, widthLoad;
  logic driveAReg, driveANext, driveBReg, driveBNext;
  always_comb begin
    if (isE1) begin
      widthLoad = PW_W'(PW_E1_CYC - 1);
    end else if (lenReg == LEN_NET_A) begin
      widthLoad = PW_W'(PW_NET_A_CYC - 1);
    end else begin
      widthLoad = PW_W'(PW_DSX_CYC - 1);
    end
    stateNext = stateReg;
    widthCntNext = widthCntReg;
    driveANext = driveAReg;
    driveBNext = driveBReg;
    case (stateReg)
      PS_IDLE: begin
        if (newBit && (symPosReg || symNegReg)) begin
          stateNext = PS_DRIVE;
          widthCntNext = widthLoad;
          driveANext = symPosReg;
          driveBNext = symNegReg;
        end
      end
      PS_DRIVE: begin
        if (txClkStatic || widthCntReg == '0) begin
          stateNext = PS_IDLE;
          driveANext = 1'b0;
          driveBNext = 1'b0;
        end else begin
          widthCntNext = widthCntReg - 1'b1;
        end
      end
      default: begin
        stateNext = PS_IDLE;
        driveANext = 1'b0;
        driveBNext = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= PS_IDLE;
      widthCntReg <= '0;
      driveAReg <= 1'b0;
      driveBReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      widthCntReg <= widthCntNext;
      driveAReg <= driveANext;
      driveBReg <= driveBNext;
    end
  end

  // Static clock wins over any pulse in flight
  assign lineOutA = driveAReg && !txClkStatic;
  assign lineOutB = driveBReg && !txClkStatic;

endmodule : lifc_top

/* File: verif/lifc_framer_model.sv */
// Purpose: Framer feeding transmit clock and data
// Assumes: 15 ns oscillator divided to a legal bit period
// Notes:   Clock stands still, data inverts every oscillator cycle outside frames
`timescale 1ns/1ps
module lifc_framer_model #(
  parameter int DIV = 32
) (
  input wire logic sendEn,
  input wire logic [1:0] symbol,
  output logic txClk,
  output logic [1:0] txDataPins
);
  logic osc;
  int phase;

  initial begin
    osc = 1'b0;
    txClk = 1'b1;
    txDataPins = 2'h0;
    phase = 0;
  end

  always #7.5 osc = ~osc;

  // Data changes on the rise, so it is steady around the falling edge
  always @(posedge osc) begin
    if (sendEn) begin
      phase <= (phase + 1) % DIV;
      if (phase == 0) begin
        txClk <= 1'b1;
        txDataPins <= symbol;
      end
      if (phase == DIV / 2) txClk <= 1'b0;
    end else begin
      txDataPins <= ~txDataPins;
    end
  end
endmodule : lifc_framer_model

/* File: verif/lifc_top_assertions.sv */
// Purpose: Port-level checks of the line interface block
// Assumes: Sees only top ports, all on ref_clk
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
module lifc_checker
  import lifc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire lifc_pkg::lifc_mode_e modeSel,
  input wire logic [2:0] lineLengthCode,
  input wire logic sendAllOnes,
  input wire logic localLoopback,
  input wire logic internalCoding,
  input wire logic aisEnable,
  input wire logic driverMonitorEnable,
  input wire logic e1Output,
  input wire logic e1NoResistor,
  input wire logic dsxSelect,
  input wire logic [2:0] dsxRange,
  input wire logic [6:0] sliceThresholdPct,
  input wire logic [5:0] ctlPinsOe,
  input wire logic lineOutA,
  input wire logic lineOutB,
  input wire logic txClkStatic,
  input wire logic txSettling
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // A stopped transmit clock must silence both line outputs
  property p_static_quiet;
    txClkStatic |-> !lineOutA && !lineOutB;
  endproperty
  a_static_quiet: assert property (p_static_quiet)
    else $error("line driven while transmit clock static");

  property p_one_polarity;
    !(lineOutA && lineOutB);
  endproperty
  a_one_polarity: assert property (p_one_polarity)
    else $error("both line outputs high");

  // Shortest pulse is the E1 width; only a static clock may cut it
  property p_width_a;
    $rose(lineOutA) |-> (lineOutA [*6]) or (##[0:5] txClkStatic);
  endproperty
  a_width_a: assert property (p_width_a)
    else $error("positive pulse too short");

  property p_width_b;
    $rose(lineOutB) |-> (lineOutB [*6]) or (##[0:5] txClkStatic);
  endproperty
  a_width_b: assert property (p_width_b)
    else $error("negative pulse too short");

  property p_end_a;
    $rose(lineOutA) |-> ##[1:9] !lineOutA;
  endproperty
  a_end_a: assert property (p_end_a)
    else $error("positive pulse too long");

  // Feature set follows the settled mode
  property p_latch_feat;
    modeSel == MODE_LATCH && $past(modeSel) == MODE_LATCH
      |-> internalCoding && aisEnable && !driverMonitorEnable;
  endproperty
  a_latch_feat: assert property (p_latch_feat)
    else $error("latched mode features wrong");

  property p_other_feat;
    modeSel != MODE_LATCH && $past(modeSel) != MODE_LATCH
      |-> !internalCoding && !aisEnable && driverMonitorEnable;
  endproperty
  a_other_feat: assert property (p_other_feat)
    else $error("pin or host mode features wrong");

  property p_e1_decode;
    $stable(lineLengthCode) && lineLengthCode <= 3'h1 |-> e1Output &&
      e1NoResistor == lineLengthCode[0] && sliceThresholdPct == SLICE_E1_PCT;
  endproperty
  a_e1_decode: assert property (p_e1_decode)
    else $error("E1 code decode wrong");

  property p_dsx_range;
    $stable(lineLengthCode) && lineLengthCode >= 3'h3 |-> dsxSelect &&
      dsxRange == lineLengthCode - 3'h3 && sliceThresholdPct == SLICE_T1_PCT;
  endproperty
  a_dsx_range: assert property (p_dsx_range)
    else $error("cable range decode wrong");

  // A send-all-ones, local loopback or line-length change must start the settling flag
  property p_settle;
    $changed({sendAllOnes, localLoopback, lineLengthCode})
      |-> ##[0:2] txSettling;
  endproperty
  a_settle: assert property (p_settle)
    else $error("settling flag missing after control change");

  property p_oe_unused;
    ctlPinsOe[5:3] == 3'h0 && !ctlPinsOe[1];
  endproperty
  a_oe_unused: assert property (p_oe_unused)
    else $error("input-only control pin driven");
endmodule : lifc_checker

/* File: verif/lifc_top_test.sv */
// Purpose: Self-checking bench of the line interface block
// Assumes: Framer model drives the link
// Notes:   Notes queue up, compared at the falling edge
`timescale 1ns/1ps
module lifc_top_test;
  import lifc_pkg::*;
  typedef struct {
    string what;
    logic [42:0] m;
    logic [42:0] v;
  } lifc_note_s;
  localparam logic [42:0] M_CFG = 43'h7fffff;
  lifc_note_s notes[$];
  lifc_note_s note;
  int errors = 0;
  int numChecks = 0;
  int fallCnt = 0;
  logic ref_clk, arst_n, txClk, sendEn, prevA, prevB, posSeen, negSeen;
  logic [1:0] modeLevelPins, txDataPins, monitorPins, symbol, rxPinsOut;
  logic [5:0] ctlPinsIn, ctlPinsOe;
  logic [7:0] markCnt;
  logic rxPositiveData, rxNegativeData, rxSingleData, bipolarViolationFlag;
  logic aisFlag, driverMonitorFlag, hostRemoteLoopback, hostLocalLoopback;
  logic hostSendAllOnes, hostSerialOut, hostInterrupt, serialChipSelectN;
  logic [2:0] hostLineLengthCode, lineLengthCode, dsxRange;
  logic remoteLoopback, localLoopback, sendAllOnes, internalCoding;
  logic aisEnable, driverMonitorEnable, e1Output, e1NoResistor, networkOptA;
  logic networkOptB, dsxSelect, lineOutA, lineOutB, txClkStatic, txSettling;
  logic statusPinOut;
  logic [6:0] sliceThresholdPct;
  lifc_mode_e modeSel;
  logic [42:0] obs;

  lifc_top dut (.ref_clk, .arst_n, .txClk, .modeLevelPins, .txDataPins,
    .monitorPins, .ctlPinsIn, .ctlPinsOut(), .ctlPinsOe, .rxPositiveData,
    .rxNegativeData, .rxSingleData, .bipolarViolationFlag, .aisFlag,
    .driverMonitorFlag, .rxPinsOut, .statusPinOut, .hostLineLengthCode,
    .hostRemoteLoopback, .hostLocalLoopback, .hostSendAllOnes,
    .hostSerialOut, .hostInterrupt, .serialChipSelectN, .serialClk(),
    .serialIn(), .outputEdgeSelect(), .monitorTipIn(), .monitorRingIn(),
    .modeSel, .lineLengthCode, .remoteLoopback, .localLoopback,
    .sendAllOnes, .rxDecoderSelect(), .internalCoding, .aisEnable,
    .driverMonitorEnable, .e1Output, .e1NoResistor, .networkOptA,
    .networkOptB, .dsxSelect, .dsxRange, .sliceThresholdPct, .lineOutA,
    .lineOutB, .txClkStatic, .txSettling);

  lifc_framer_model #(.DIV(32)) framer (.sendEn, .symbol, .txClk,
    .txDataPins);

  // Observed outputs packed in the same order as the expected notes
  assign obs = {serialChipSelectN, sendAllOnes, localLoopback,
    remoteLoopback, negSeen, posSeen, markCnt, txClkStatic, txSettling,
    ctlPinsOe[0], statusPinOut, rxPinsOut, sliceThresholdPct, dsxRange,
    dsxSelect, networkOptB, networkOptA, e1NoResistor, e1Output,
    driverMonitorEnable, aisEnable, internalCoding, lineLengthCode, modeSel};

  always #20 ref_clk = ~ref_clk;
  always @(negedge txClk) fallCnt <= fallCnt + 1;

  // Count line pulses by their rising edge
  always @(posedge ref_clk) begin
    prevA <= lineOutA;
    prevB <= lineOutB;
    if (lineOutA && !prevA) posSeen <= 1'b1;
    if (lineOutB && !prevB) negSeen <= 1'b1;
    if (lineOutA && !prevA || lineOutB && !prevB) markCnt <= markCnt + 8'h1;
  end

  // Compare oldest notes once the edge's updates have settled
  always @(negedge ref_clk) begin
    while (notes.size() > 0) begin
      note = notes.pop_front();
      numChecks++;
      if (((obs ^ note.v) & note.m) !== 43'h0) begin
        errors++;
        $display("mismatch %s expected %h seen %h", note.what,
          note.v & note.m, obs & note.m);
      end
    end
  end

  function automatic logic [42:0] exp_cfg(input logic [1:0] m,
                                          input logic [2:0] c);
    logic e1;
    logic dsx;
    e1 = c <= 3'h1;
    dsx = c >= 3'h3;
    return {20'h0, e1 ? SLICE_E1_PCT : SLICE_T1_PCT, dsx ? c - 3'h3 : 3'h0,
      dsx, c == 3'h3, c == 3'h2, c == 3'h1, e1, m != MODE_LATCH,
      m == MODE_LATCH, m == MODE_LATCH, c, m};
  endfunction : exp_cfg

  task automatic check(input string what, input logic [42:0] m,
                       input logic [42:0] v);
    notes.push_back('{what, m, v});
  endtask : check

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_clk

  task automatic drive_rx();
    {rxPositiveData, rxNegativeData, rxSingleData} <= 3'($urandom);
    {bipolarViolationFlag, aisFlag, driverMonitorFlag} <= 3'($urandom);
  endtask : drive_rx

  // One framed burst in pin mode, then a stop long enough to go static
  task automatic tx_run(input logic [1:0] s, input logic [5:0] c,
      input logic [42:0] m, input logic [42:0] v, input logic marks);
    modeLevelPins <= 2'h1;
    {rxPositiveData, rxNegativeData} <= 2'h0;
    ctlPinsIn <= c;
    symbol <= s;
    wait_clk(60);
    sendEn <= 1'b1;
    // Link config copy only moves on link edges, so prime it first
    wait_clk(60);
    @(posedge txClk);
    wait_clk(1);
    {markCnt, posSeen, negSeen} <= 10'h0;
    fallCnt = 0;
    wait_clk(400);
    sendEn <= 1'b0;
    wait_clk(60);
    check("tx", m | 43'hff << 29 | 43'h3 << 27,
      v | 43'(marks ? fallCnt[7:0] : 8'h0) << 29 | 43'h1 << 28);
  endtask : tx_run

  task automatic end_of_test();
    if (errors == 0 && numChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    #(40 * 6000);
    errors++;
    end_of_test();
  end

  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {sendEn, symbol, prevA, prevB, posSeen, negSeen, markCnt} = 14'h0;
    {modeLevelPins, monitorPins, ctlPinsIn} = 10'h100;
    {rxPositiveData, rxNegativeData, rxSingleData} = 3'h0;
    {bipolarViolationFlag, aisFlag, driverMonitorFlag} = 3'h0;
    {hostRemoteLoopback, hostLocalLoopback, hostSendAllOnes} = 3'h0;
    {hostLineLengthCode, hostSerialOut, hostInterrupt} = 5'h0;
    void'($urandom(27332));
    wait_clk(4);
    check("reset", M_CFG | 43'h1 << 42 | 43'h1 << 28,
      exp_cfg(MODE_PIN, 3'h0) | 43'h1 << 42 | 43'h1 << 28);
    wait_clk(1);
    arst_n <= 1'b1;
    wait_clk(4);
    for (int i = 0; i < 8; i++) begin
      ctlPinsIn <= 6'(i);
      drive_rx();
      wait_clk(6);
      check("pin cfg", M_CFG | 43'h1 << 27,
        exp_cfg(MODE_PIN, 3'(i)) | 43'(i != 0) << 27);
      check("pin rx", 43'h7 << 23, 43'({driverMonitorFlag, rxPositiveData,
        rxNegativeData}) << 23);
    end
    modeLevelPins <= 2'h0;
    wait_clk(8);
    check("latch open", M_CFG, exp_cfg(MODE_LATCH, 3'h7));
    monitorPins <= 2'h2;
    wait_clk(4);
    ctlPinsIn <= 6'h5;
    drive_rx();
    wait_clk(6);
    check("latch hold", M_CFG, exp_cfg(MODE_LATCH, 3'h7));
    check("latch rx", 43'h7 << 23, 43'({aisFlag, rxSingleData,
      bipolarViolationFlag}) << 23);
    monitorPins <= 2'h0;
    wait_clk(6);
    check("latch pass", M_CFG, exp_cfg(MODE_LATCH, 3'h5));
    modeLevelPins <= 2'h2;
    hostLineLengthCode <= 3'($urandom);
    ctlPinsIn <= 6'($urandom);
    wait_clk(8);
    check("host", M_CFG | 43'h3 << 41 | 43'h1 << 26,
      exp_cfg(MODE_HOST, hostLineLengthCode) | 43'(ctlPinsIn[3]) << 42 |
      43'h1 << 26);
    tx_run(2'h1, 6'h04, 43'h3 << 37, 43'h1 << 37, 1'b1);
    tx_run(2'h0, 6'h24, 43'h3 << 37 | 43'h1 << 41,
      43'h3 << 37 | 43'h1 << 41, 1'b1);
    tx_run(2'h0, 6'h2c, 43'h1 << 39, 43'h1 << 39 | 43'h1 << 27,
      1'b0);
    wait_clk(2);
    end_of_test();
  end
endmodule : lifc_top_test

bind lifc_top lifc_checker chk (.*);
